// ---- pkg/soft_reset_pkg.sv ----
// Operation
// - first control register accepts written bits only where capability mask one allows
// - second control register accepts written bits only where capability mask two allows
// - first control register at offset 0x040, read/write, clears to zero on reset
// - second control register at offset 0x044, clears to zero on reset
// - reserved bits read zero and ignore writes; software preserves them
// - first register bit 20 resets the pulse-width modulation module
// - first register bit 16 resets converter module 0
// - first register bit 6 resets the hibernation module
// - first register bit 3 resets the watchdog unit
// - second register bits 26..24 reset comparators 2, 1, 0
// - second register bits 18..16 reset general-purpose timers 2, 1, 0
// - second register bit 12 resets two-wire unit 0
// - second register bit 8 resets quadrature encoder unit 0
// - second register bit 4 resets synchronous serial unit 0
// - second register bits 2..0 reset asynchronous serial units 2, 1, 0
package soft_reset_pkg;

  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;

  localparam logic [11:0] OFS_GROUP0 = 12'h040;
  localparam logic [11:0] OFS_GROUP1 = 12'h044;
  localparam logic [31:0] RESET_VAL  = 32'h0000_0000;

  // group 0 field positions
  localparam int          BIT_PWM    = 20;
  localparam int          BIT_ADC    = 16;
  localparam int          BIT_HIB    = 6;
  localparam int          BIT_WDOG   = 3;

  // group 1 field positions
  localparam int          BIT_COMPARATOR0_RESET_BIT  = 24;
  localparam int          BIT_GP_RESET_BIT_A = 16;
  localparam int          BIT_TWI0   = 12;
  localparam int          BIT_QENC0  = 8;
  localparam int          BIT_SSER0  = 4;
  localparam int          BIT_ASER0  = 0;
  localparam int          NUM_COMP   = 3;
  localparam int          NUM_TIMER  = 3;
  localparam int          NUM_ASER   = 3;

  // implemented (non-reserved) bits of each register
  localparam logic [31:0] IMPL_GROUP0 = 32'h0011_0048;
  localparam logic [31:0] IMPL_GROUP1 = 32'h0707_1117;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_GROUP0,
    SEL_GROUP1
  } reg_sel_t;

  function automatic reg_sel_t decodeAddr(input logic [11:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == OFS_GROUP0) begin
      sel = SEL_GROUP0;
    end else if (addr == OFS_GROUP1) begin
      sel = SEL_GROUP1;
    end
    return sel;
  endfunction : decodeAddr

endpackage : soft_reset_pkg

// ---- rtl/peripheral_soft_reset_regs.sv ----
`timescale 1ns/1ns
module peripheral_soft_reset_regs (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] capabilityMaskOne,
  input  wire logic [31:0] capabilityMaskTwo,
  output logic             pwmReset,
  output logic             adcReset,
  output logic             hibernationReset,
  output logic             watchdogReset,
  output logic      [2:0]  comparatorReset,
  output logic      [2:0]  timerReset,
  output logic             twoWire0Reset,
  output logic             quadEncoder0Reset,
  output logic             syncSerial0Reset,
  output logic      [2:0]  asyncSerialReset
);

  logic [31:0]              group0_r;
  logic [31:0]              group1_r;
  logic [31:0]              prdata_r;
  logic [31:0]              writeEn0;
  logic [31:0]              writeEn1;
  logic [31:0]              readVal;
  soft_reset_pkg::reg_sel_t setupSel;
  soft_reset_pkg::reg_sel_t accessSel;
  logic                     accessCyc;
  logic                     wrGroup0;
  logic                     wrGroup1;

  // zero wait states: every access completes in its first access cycle
  assign pready    = 1'b1;
  assign accessCyc = psel && penable;
  assign setupSel  = soft_reset_pkg::decodeAddr(paddr);
  assign accessSel = setupSel;
  assign pslverr   = accessCyc && (accessSel == soft_reset_pkg::SEL_NONE);
  assign wrGroup0  = accessCyc && pwrite && (accessSel == soft_reset_pkg::SEL_GROUP0);
  assign wrGroup1  = accessCyc && pwrite && (accessSel == soft_reset_pkg::SEL_GROUP1);

  // absent peripherals and reserved bits keep their value on write
  assign writeEn0 = soft_reset_pkg::IMPL_GROUP0 & capabilityMaskOne;
  assign writeEn1 = soft_reset_pkg::IMPL_GROUP1 & capabilityMaskTwo;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      group0_r <= soft_reset_pkg::RESET_VAL;
    end else if (wrGroup0) begin
      group0_r <= (group0_r & ~writeEn0) | (pwdata & writeEn0);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      group1_r <= soft_reset_pkg::RESET_VAL;
    end else if (wrGroup1) begin
      group1_r <= (group1_r & ~writeEn1) | (pwdata & writeEn1);
    end
  end

  always_comb begin
    case (setupSel)
      soft_reset_pkg::SEL_GROUP0: readVal = group0_r & soft_reset_pkg::IMPL_GROUP0;
      soft_reset_pkg::SEL_GROUP1: readVal = group1_r & soft_reset_pkg::IMPL_GROUP1;
      default:                    readVal = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= readVal;
    end
  end

  assign prdata = prdata_r;

  // reset lines are the register bits themselves, so they glitch-free follow the flops
  assign pwmReset          = group0_r[soft_reset_pkg::BIT_PWM];
  assign adcReset          = group0_r[soft_reset_pkg::BIT_ADC];
  assign hibernationReset  = group0_r[soft_reset_pkg::BIT_HIB];
  assign watchdogReset     = group0_r[soft_reset_pkg::BIT_WDOG];
  assign twoWire0Reset     = group1_r[soft_reset_pkg::BIT_TWI0];
  assign quadEncoder0Reset = group1_r[soft_reset_pkg::BIT_QENC0];
  assign syncSerial0Reset  = group1_r[soft_reset_pkg::BIT_SSER0];

  for (genvar i = 0; i < 3; i++) begin : g_triple
    assign comparatorReset[i]  = group1_r[soft_reset_pkg::BIT_COMPARATOR0_RESET_BIT + i];
    assign timerReset[i]       = group1_r[soft_reset_pkg::BIT_GP_RESET_BIT_A + i];
    assign asyncSerialReset[i] = group1_r[soft_reset_pkg::BIT_ASER0 + i];
  end

  // ------------------------------------------------------------------ checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_readSetup0;
    psel && !penable && !pwrite && (paddr == soft_reset_pkg::OFS_GROUP0);
  endsequence

  sequence s_readSetup1;
    psel && !penable && !pwrite && (paddr == soft_reset_pkg::OFS_GROUP1);
  endsequence

  sequence s_write0;
    psel && penable && pwrite && (paddr == soft_reset_pkg::OFS_GROUP0);
  endsequence

  sequence s_write1;
    psel && penable && pwrite && (paddr == soft_reset_pkg::OFS_GROUP1);
  endsequence

  AST_G0_MASKED_BITS_KEEP:
    assert property (s_write0 |=> ((group0_r & ~$past(writeEn0)) ==
                                   ($past(group0_r) & ~$past(writeEn0))))
      else $error("group0 changed a bit that capability mask forbids");

  AST_G0_ENABLED_BITS_TAKE:
    assert property (s_write0 |=> ((group0_r & $past(writeEn0)) ==
                                   ($past(pwdata) & $past(writeEn0))))
      else $error("group0 did not take enabled written bits");

  AST_G1_MASKED_BITS_KEEP:
    assert property (s_write1 |=> ((group1_r & ~$past(writeEn1)) ==
                                   ($past(group1_r) & ~$past(writeEn1))))
      else $error("group1 changed a bit that capability mask forbids");

  AST_G1_ENABLED_BITS_TAKE:
    assert property (s_write1 |=> ((group1_r & $past(writeEn1)) ==
                                   ($past(pwdata) & $past(writeEn1))))
      else $error("group1 did not take enabled written bits");

  AST_G0_READBACK:
    assert property (s_readSetup0 ##1 (psel && penable) |->
                     (prdata == (group0_r & soft_reset_pkg::IMPL_GROUP0)) && !pslverr)
      else $error("group0 read returned wrong data");

  AST_G1_READBACK:
    assert property (s_readSetup1 ##1 (psel && penable) |->
                     (prdata == (group1_r & soft_reset_pkg::IMPL_GROUP1)) && !pslverr)
      else $error("group1 read returned wrong data");

  AST_RESERVED_ZERO:
    assert property (((group0_r & ~soft_reset_pkg::IMPL_GROUP0) == 32'h0000_0000) &&
                     ((group1_r & ~soft_reset_pkg::IMPL_GROUP1) == 32'h0000_0000))
      else $error("reserved bit became set");

  // a line whose bit is not writable keeps its old value, it is not forced low
  AST_GROUP0_LINES:
    assert property (s_write0 |=>
                     (pwmReset == $past((pwdata[20] & writeEn0[20]) |
                                        (pwmReset & ~writeEn0[20]))) &&
                     (adcReset == $past((pwdata[16] & writeEn0[16]) |
                                        (adcReset & ~writeEn0[16]))) &&
                     (hibernationReset == $past((pwdata[6] & writeEn0[6]) |
                                                (hibernationReset & ~writeEn0[6]))) &&
                     (watchdogReset == $past((pwdata[3] & writeEn0[3]) |
                                             (watchdogReset & ~writeEn0[3]))))
      else $error("group0 reset line does not follow written bit");

  AST_GROUP1_LINES:
    assert property (s_write1 |=>
                     (comparatorReset == $past((pwdata[26:24] & writeEn1[26:24]) |
                                               (comparatorReset & ~writeEn1[26:24]))) &&
                     (timerReset == $past((pwdata[18:16] & writeEn1[18:16]) |
                                          (timerReset & ~writeEn1[18:16]))) &&
                     (twoWire0Reset == $past((pwdata[12] & writeEn1[12]) |
                                             (twoWire0Reset & ~writeEn1[12]))) &&
                     (quadEncoder0Reset == $past((pwdata[8] & writeEn1[8]) |
                                                 (quadEncoder0Reset & ~writeEn1[8]))) &&
                     (syncSerial0Reset == $past((pwdata[4] & writeEn1[4]) |
                                                (syncSerial0Reset & ~writeEn1[4]))) &&
                     (asyncSerialReset == $past((pwdata[2:0] & writeEn1[2:0]) |
                                                (asyncSerialReset & ~writeEn1[2:0]))))
      else $error("group1 reset line does not follow written bit");

  AST_HOLD_UNTIL_WRITE:
    assert property ((watchdogReset || timerReset[0]) && !wrGroup0 && !wrGroup1 |=>
                     (watchdogReset == $past(watchdogReset)) &&
                     (timerReset[0] == $past(timerReset[0])))
      else $error("peripheral left reset without a write");

  sequence s_clearWdog;
    psel && penable && pwrite && (paddr == soft_reset_pkg::OFS_GROUP0) &&
    writeEn0[soft_reset_pkg::BIT_WDOG] && !pwdata[soft_reset_pkg::BIT_WDOG];
  endsequence

  sequence s_setHib;
    psel && penable && pwrite && (paddr == soft_reset_pkg::OFS_GROUP0) &&
    writeEn0[soft_reset_pkg::BIT_HIB] && pwdata[soft_reset_pkg::BIT_HIB];
  endsequence

  sequence s_clearTimer0;
    psel && penable && pwrite && (paddr == soft_reset_pkg::OFS_GROUP1) &&
    writeEn1[soft_reset_pkg::BIT_GP_RESET_BIT_A] && !pwdata[soft_reset_pkg::BIT_GP_RESET_BIT_A];
  endsequence

  sequence s_setComp0;
    psel && penable && pwrite && (paddr == soft_reset_pkg::OFS_GROUP1) &&
    writeEn1[soft_reset_pkg::BIT_COMPARATOR0_RESET_BIT] && pwdata[soft_reset_pkg::BIT_COMPARATOR0_RESET_BIT];
  endsequence

  sequence s_unmappedWrite;
    psel && penable && pwrite &&
    (paddr != soft_reset_pkg::OFS_GROUP0) && (paddr != soft_reset_pkg::OFS_GROUP1);
  endsequence

  sequence s_absentWdogWrite;
    psel && penable && pwrite && (paddr == soft_reset_pkg::OFS_GROUP0) &&
    !capabilityMaskOne[soft_reset_pkg::BIT_WDOG];
  endsequence

  sequence s_absentAser0Write;
    psel && penable && pwrite && (paddr == soft_reset_pkg::OFS_GROUP1) &&
    !capabilityMaskTwo[soft_reset_pkg::BIT_ASER0];
  endsequence

  AST_WDOG_RELEASE:
    assert property (s_clearWdog |=> !watchdogReset)
      else $error("watchdog not released after its bit was cleared");

  AST_HIB_HOLD:
    assert property (s_setHib |=> hibernationReset)
      else $error("hibernation not held after its bit was set");

  AST_GP_RESET_BIT_A_RELEASE:
    assert property (s_clearTimer0 |=> !timerReset[0])
      else $error("timer 0 not released after its bit was cleared");

  AST_COMPARATOR0_RESET_BIT_HOLD:
    assert property (s_setComp0 |=> comparatorReset[0])
      else $error("comparator 0 not held after its bit was set");

  // an absent peripheral must not see its reset line move on a write
  AST_ABSENT_WDOG_KEEPS:
    assert property (s_absentWdogWrite |=> (watchdogReset == $past(watchdogReset)))
      else $error("absent watchdog bit took a write");

  AST_ABSENT_ASER0_KEEPS:
    assert property (s_absentAser0Write |=> (asyncSerialReset[0] == $past(asyncSerialReset[0])))
      else $error("absent serial unit bit took a write");

  AST_UNMAPPED_NO_EFFECT:
    assert property (s_unmappedWrite |=>
                     (group0_r == $past(group0_r)) && (group1_r == $past(group1_r)))
      else $error("write to unmapped address changed a register");

  AST_G0_IDLE_STABLE:
    assert property (!wrGroup0 |=> (group0_r == $past(group0_r)))
      else $error("group0 changed without a write");

  AST_G1_IDLE_STABLE:
    assert property (!wrGroup1 |=> (group1_r == $past(group1_r)))
      else $error("group1 changed without a write");

  // read data stands from its setup edge until the next read setup
  AST_PRDATA_STANDS:
    assert property (!(psel && !penable && !pwrite) |=> (prdata == $past(prdata)))
      else $error("read data moved outside a read setup");

  AST_UNMAPPED_READ_ZERO:
    assert property (psel && !penable && !pwrite &&
                     (paddr != soft_reset_pkg::OFS_GROUP0) &&
                     (paddr != soft_reset_pkg::OFS_GROUP1) |=>
                     (prdata == 32'h0000_0000))
      else $error("unmapped read returned nonzero data");

  AST_READ_RESERVED_ZERO:
    assert property (((prdata & ~soft_reset_pkg::IMPL_GROUP0 & ~soft_reset_pkg::IMPL_GROUP1)
                      == 32'h0000_0000))
      else $error("read data shows a reserved bit");

  AST_G0_CLEAR_LINES_LOW:
    assert property ((group0_r == 32'h0000_0000) |->
                     !pwmReset && !adcReset && !hibernationReset && !watchdogReset)
      else $error("group0 line held with its register clear");

  AST_G1_CLEAR_LINES_LOW:
    assert property ((group1_r == 32'h0000_0000) |->
                     (comparatorReset == 3'h0) && (timerReset == 3'h0) &&
                     !twoWire0Reset && !quadEncoder0Reset && !syncSerial0Reset &&
                     (asyncSerialReset == 3'h0))
      else $error("group1 line held with its register clear");

  AST_MAPPED_NO_ERROR:
    assert property (psel && penable && ((paddr == soft_reset_pkg::OFS_GROUP0) ||
                                         (paddr == soft_reset_pkg::OFS_GROUP1)) |->
                     pready && !pslverr)
      else $error("mapped access flagged an error");

endmodule : peripheral_soft_reset_regs

// ---- verif/peripheral_soft_reset_regs_tb.sv ----
`timescale 1ns/1ns
module peripheral_soft_reset_regs_tb;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, maskOne, maskTwo, rd;
  logic        pwmR, adcR, hibR, wdR, twR, qeR, ssR, err;
  logic [2:0]  cmpR, tmrR, asR;
  int          miscompares, n_tests, cycles;
  localparam logic [11:0] G0 = 12'h040;
  localparam logic [11:0] G1 = 12'h044;
  localparam logic [31:0] I0 = 32'h0011_0048;
  localparam logic [31:0] I1 = 32'h0707_1117;

  peripheral_soft_reset_regs u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capabilityMaskOne(maskOne), .capabilityMaskTwo(maskTwo),
    .pwmReset(pwmR), .adcReset(adcR), .hibernationReset(hibR), .watchdogReset(wdR),
    .comparatorReset(cmpR), .timerReset(tmrR), .twoWire0Reset(twR),
    .quadEncoder0Reset(qeR), .syncSerial0Reset(ssR), .asyncSerialReset(asR));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done;
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // long enough for every scenario with a wide margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares = miscompares + 1;
      test_done();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // leaves psel high so a following transfer runs back to back
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
  endtask : apb

  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask : rdchk

  // idles the bus and samples the reset lines mid-cycle
  task automatic outchk(input logic [31:0] e0, input logic [31:0] e1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
    chk("grp0 lines", {e0[20], e0[16], e0[6], e0[3]}, {pwmR, adcR, hibR, wdR});
    chk("grp1 cmp", e1[26:24], cmpR);
    chk("grp1 tmr", e1[18:16], tmrR);
    chk("grp1 misc", {e1[12], e1[8], e1[4]}, {twR, qeR, ssR});
    chk("grp1 aser", e1[2:0], asR);
    @(posedge clk);
  endtask : outchk

  task automatic t_all;
    apb(1'b1, G0, 32'hFFFF_FFFF);
    apb(1'b1, G1, 32'hFFFF_FFFF);
    outchk(I0, I1);
    rdchk("grp0 ones", G0, I0);
    rdchk("grp1 ones", G1, I1);
  endtask : t_all

  task automatic t_mask;
    maskOne <= 32'h0001_0008;
    maskTwo <= 32'h0101_0101;
    apb(1'b1, G0, 32'h0000_0000);
    apb(1'b1, G1, 32'h0000_0000);
    rdchk("grp0 masked", G0, I0 & ~32'h0001_0008);
    rdchk("grp1 masked", G1, I1 & ~32'h0101_0101);
    maskOne <= 32'hFFFF_FFFF;
    maskTwo <= 32'hFFFF_FFFF;
    apb(1'b1, G0, 32'h0000_0000);
    apb(1'b1, G1, 32'h0000_0000);
    outchk(32'h0000_0000, 32'h0000_0000);
  endtask : t_mask

  task automatic t_unmapped;
    apb(1'b1, 12'h048, 32'hFFFF_FFFF);
    chk("wr err", 32'h1, {31'h0, err});
    rdchk("rd unmapped", 12'h048, 32'h0000_0000);
    chk("rd err", 32'h1, {31'h0, err});
    rdchk("grp0 kept", G0, 32'h0000_0000);
    chk("mapped err", 32'h0, {31'h0, err});
    outchk(32'h0000_0000, 32'h0000_0000);
  endtask : t_unmapped

  task automatic t_reset;
    t_all();
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdchk("grp0 rst", G0, 32'h0000_0000);
    rdchk("grp1 rst", G1, 32'h0000_0000);
    outchk(32'h0000_0000, 32'h0000_0000);
  endtask : t_reset

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    maskOne = 32'hFFFF_FFFF;
    maskTwo = 32'hFFFF_FFFF;
    miscompares = 0;
    n_tests = 0;
    cycles = 0;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdchk("grp0 init", G0, 32'h0000_0000);
    rdchk("grp1 init", G1, 32'h0000_0000);
    outchk(32'h0000_0000, 32'h0000_0000);
    t_all();
    t_mask();
    t_unmapped();
    t_reset();
    test_done();
  end
endmodule : peripheral_soft_reset_regs_tb
